// *** core/startup_ctrl.sv ***
// How it works
// - Serial port answers only after full initialization
// - Bit 1 of 0x1a selects bus level
// - Bias release loads memory, then finds offset
// - Reference ramps at 1 or 2 mV/us
// - Minimum on-time pulses until output rises
// - Nine-bit target spans 0x12 bit 0, 0x13
// - Overcurrent and overvoltage stay active during ramp
// - Pre-bias: switches off until ramp passes feedback
// - Power good waits for first high pulse
// - Enable low kills drivers and ramp at once
// - Soft-stop ramps down, drivers off at zero
// - Arm and request bits reset to zero
// - Address is base plus strap offset
// - Strap resistance bands map to offsets 0-7
`timescale 1ns/1ps
`default_nettype none
module startup_ctrl import regulator_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic bias_undervoltage_lockout,
	input wire logic nvm_load_done,
	input wire logic [8:0] nvm_vout_code,
	input wire logic [7:0] nvm_base_address,
	input wire logic [7:0] strap_kohm,
	input wire logic strap_valid,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic enable_pin,
	input wire logic pwm_request,
	input wire logic [8:0] feedback_sense,
	input wire logic pg_compare,
	input wire logic overcurrent_trip,
	input wire logic overvoltage_trip,
	output logic high_side_drive,
	output logic low_side_drive,
	output logic min_on_time,
	output logic [8:0] reference_code,
	output logic bus_level_high,
	output logic power_good_output,
	output logic power_good_oe,
	output logic port_ready
);
	ramp_link_if lnk ();

	soft_ramp u_ramp (
		.core_clk(core_clk),
		.srst(srst),
		.lnk(lnk.ramp)
	);

	strap_offset u_strap (
		.core_clk(core_clk),
		.srst(srst),
		.lnk(lnk.strap)
	);

	// Start-up sequencer
	seq_t seq_r, seq_nxt;
	logic [3:0] init_cnt_r;

	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SEQ_LOCKOUT: begin
				seq_nxt = SEQ_NVM;
			end
			SEQ_NVM: begin
				if (nvm_load_done) begin
					seq_nxt = SEQ_INIT;
				end
			end
			SEQ_INIT: begin
				if (init_cnt_r == INIT_CYCLES - 4'h1) begin
					seq_nxt = SEQ_ADDR;
				end
			end
			SEQ_ADDR: begin
				if (lnk.offset_held) begin
					seq_nxt = SEQ_READY;
				end
			end
			SEQ_READY: begin
				seq_nxt = SEQ_READY;
			end
			default: begin
				seq_nxt = SEQ_LOCKOUT;
			end
		endcase
		if (bias_undervoltage_lockout) begin
			seq_nxt = SEQ_LOCKOUT;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			seq_r <= SEQ_LOCKOUT;
			init_cnt_r <= 4'h0;
		end else begin
			seq_r <= seq_nxt;
			init_cnt_r <= (seq_r == SEQ_INIT) ? init_cnt_r + 4'h1 : 4'h0;
		end
	end

	wire in_lockout = (seq_r == SEQ_LOCKOUT);
	wire nvm_take = (seq_r == SEQ_NVM) && nvm_load_done;
	assign port_ready = (seq_r == SEQ_READY);
	assign lnk.strap_capture = (seq_r == SEQ_ADDR);
	assign lnk.strap_clear = in_lockout;
	assign lnk.strap_kohm = strap_kohm;
	assign lnk.strap_valid = strap_valid;

	// Working registers
	logic vout_msb_r, rate_fast_r, stop_req_r, bus_level_r, stop_arm_r;
	logic [7:0] vout_lsb_r, base_addr_r;

	logic wr_en;
	logic [7:0] ptr_r;
	logic [7:0] rx_byte;
	wire reg_reset = srst || in_lockout;
	wire wr_vhi = wr_en && (ptr_r == REG_VOUT_HIGH);
	wire wr_vlo = wr_en && (ptr_r == REG_VOUT_LOW);
	wire wr_ramp = wr_en && (ptr_r == REG_RAMP_CTRL);
	wire wr_bus = wr_en && (ptr_r == REG_BUS_LEVEL);
	wire wr_arm = wr_en && (ptr_r == REG_STOP_ARM);
	wire wr_base = wr_en && (ptr_r == REG_BASE_ADDR);

	always_ff @(posedge core_clk) begin
		if (reg_reset) begin
			vout_msb_r <= 1'b0;
			vout_lsb_r <= CTRL_RESET;
			rate_fast_r <= CTRL_RESET[RATE_BIT];
			stop_req_r <= CTRL_RESET[STOP_REQ_BIT];
			bus_level_r <= CTRL_RESET[BUS_LEVEL_BIT];
			stop_arm_r <= CTRL_RESET[STOP_ARM_BIT];
			base_addr_r <= BASE_ADDR_RESET;
		end else if (nvm_take) begin
			vout_msb_r <= nvm_vout_code[8];
			vout_lsb_r <= nvm_vout_code[7:0];
			base_addr_r <= nvm_base_address;
		end else begin
			if (wr_vhi) vout_msb_r <= rx_byte[VOUT_MSB_BIT];
			if (wr_vlo) vout_lsb_r <= rx_byte;
			if (wr_ramp) begin
				rate_fast_r <= rx_byte[RATE_BIT];
				stop_req_r <= rx_byte[STOP_REQ_BIT];
			end
			if (wr_bus) bus_level_r <= rx_byte[BUS_LEVEL_BIT];
			if (wr_arm) stop_arm_r <= rx_byte[STOP_ARM_BIT];
			if (wr_base) base_addr_r <= rx_byte;
		end
	end

	assign bus_level_high = bus_level_r;

	// Power stage gating
	logic ovp_latch_r, drive_allow_r, first_pulse_r, min_on_r, pg_r;

	wire fault = ovp_latch_r || overcurrent_trip;
	wire soft_stop = stop_req_r && stop_arm_r;
	wire hard_off = !enable_pin || !port_ready || fault;
	assign lnk.hard_off = hard_off;
	assign lnk.run = !soft_stop;
	assign lnk.fast_rate = rate_fast_r;
	assign lnk.target = {vout_msb_r, vout_lsb_r};
	wire ramp_above_fb = (lnk.ss_level > feedback_sense);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ovp_latch_r <= 1'b0;
		end else if (overvoltage_trip || !enable_pin) begin
			ovp_latch_r <= overvoltage_trip;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || hard_off || (soft_stop && lnk.at_zero)) begin
			drive_allow_r <= 1'b0;
			first_pulse_r <= 1'b0;
		end else begin
			if (ramp_above_fb && !soft_stop) drive_allow_r <= 1'b1;
			if (drive_allow_r && pwm_request) first_pulse_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			min_on_r <= 1'b0;
			pg_r <= 1'b0;
		end else begin
			min_on_r <= drive_allow_r && (feedback_sense < MIN_ON_EXIT_CODE);
			pg_r <= first_pulse_r && pg_compare && !fault;
		end
	end

	assign high_side_drive = drive_allow_r && pwm_request && !hard_off;
	assign low_side_drive = drive_allow_r && first_pulse_r && !pwm_request && !hard_off;
	assign min_on_time = min_on_r;
	assign reference_code = lnk.ss_level;
	assign power_good_output = 1'b0;
	assign power_good_oe = !pg_r;

	// Serial configuration port
	bus_t bus_r, bus_nxt;
	logic scl_q, sda_q;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt, ptr_nxt, tx_r, tx_nxt;
	logic first_r, first_nxt, rw_r, rw_nxt, oe_r;

	wire scl_rise = scl_in && !scl_q;
	wire scl_fall = !scl_in && scl_q;
	wire start_seen = scl_in && scl_q && sda_q && !sda_in;
	wire stop_seen = scl_in && scl_q && !sda_q && sda_in;
	assign rx_byte = {sh_r[6:0], sda_in};
	wire [6:0] dev_addr = 7'(base_addr_r + {5'h00, lnk.offset});
	wire [7:0] status = {5'h00, ovp_latch_r, first_pulse_r, lnk.at_target};
	wire [7:0] rd_data = (ptr_r == REG_VOUT_HIGH) ? {7'h00, vout_msb_r} :
		(ptr_r == REG_VOUT_LOW) ? vout_lsb_r :
		(ptr_r == REG_RAMP_CTRL) ? {4'h0, rate_fast_r, stop_req_r, 2'b00} :
		(ptr_r == REG_BUS_LEVEL) ? {6'h00, bus_level_r, 1'b0} :
		(ptr_r == REG_STOP_ARM) ? {4'h0, stop_arm_r, 3'h0} :
		(ptr_r == REG_BASE_ADDR) ? base_addr_r :
		(ptr_r == REG_STATUS) ? status : 8'h00;

	always_comb begin
		bus_nxt = bus_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		tx_nxt = tx_r;
		first_nxt = first_r;
		rw_nxt = rw_r;
		wr_en = 1'b0;
		if (!port_ready || stop_seen) begin
			bus_nxt = BUS_IDLE;
		end else if (start_seen) begin
			bus_nxt = BUS_ADDR;
			cnt_nxt = 3'h0;
		end else if (scl_rise) begin
			case (bus_r)
				BUS_ADDR, BUS_RX: begin
					sh_nxt = rx_byte;
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == BIT_LAST && bus_r == BUS_ADDR) begin
						if (rx_byte[7:1] == dev_addr) begin
							bus_nxt = BUS_ACK_ADDR;
							rw_nxt = rx_byte[0];
							first_nxt = 1'b1;
						end else begin
							bus_nxt = BUS_IDLE;
						end
					end else if (cnt_r == BIT_LAST) begin
						bus_nxt = BUS_ACK_RX;
						first_nxt = 1'b0;
						if (first_r) begin
							ptr_nxt = rx_byte;
						end else begin
							wr_en = 1'b1;
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				BUS_ACK_ADDR: begin
					cnt_nxt = 3'h0;
					tx_nxt = rd_data;
					bus_nxt = rw_r ? BUS_TX : BUS_RX;
				end
				BUS_ACK_RX: begin
					cnt_nxt = 3'h0;
					bus_nxt = BUS_RX;
				end
				BUS_TX: begin
					tx_nxt = {tx_r[6:0], 1'b0};
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == BIT_LAST) begin
						bus_nxt = BUS_ACK_TX;
						ptr_nxt = ptr_r + 8'h01;
					end
				end
				BUS_ACK_TX: begin
					cnt_nxt = 3'h0;
					tx_nxt = rd_data;
					bus_nxt = sda_in ? BUS_IDLE : BUS_TX;
				end
				default: begin
					bus_nxt = BUS_IDLE;
				end
			endcase
		end
	end

	// Data changes only while the clock line is low
	wire oe_nxt = (bus_r == BUS_ACK_ADDR) || (bus_r == BUS_ACK_RX) || ((bus_r == BUS_TX) && !tx_r[7]);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			bus_r <= BUS_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			tx_r <= 8'h00;
			first_r <= 1'b0;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			bus_r <= bus_nxt;
			scl_q <= scl_in;
			sda_q <= sda_in;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			tx_r <= tx_nxt;
			first_r <= first_nxt;
			rw_r <= rw_nxt;
			if (bus_nxt == BUS_IDLE) oe_r <= 1'b0;
			else if (scl_fall) oe_r <= oe_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_r;
endmodule // startup_ctrl
`default_nettype wire

// *** core/regulator_pkg.sv ***
package regulator_pkg;

	// Register map (byte pointer on the serial port)
	localparam logic [7:0] REG_VOUT_HIGH = 8'h12;
	localparam logic [7:0] REG_VOUT_LOW = 8'h13;
	localparam logic [7:0] REG_RAMP_CTRL = 8'h14;
	localparam logic [7:0] REG_BUS_LEVEL = 8'h1a;
	localparam logic [7:0] REG_STOP_ARM = 8'h1c;
	localparam logic [7:0] REG_BASE_ADDR = 8'h1e;
	localparam logic [7:0] REG_STATUS = 8'h1f;

	// Field positions
	localparam int VOUT_MSB_BIT = 0;
	localparam int STOP_REQ_BIT = 2;
	localparam int RATE_BIT = 3;
	localparam int BUS_LEVEL_BIT = 1;
	localparam int STOP_ARM_BIT = 3;

	// Reset values
	localparam logic [7:0] BASE_ADDR_RESET = 8'h08;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Soft-start timing: one reference step of 10 mV at 1 or 2 mV/us
	localparam int CLK_MHZ = 200;
	localparam int STEP_MV = 10;
	localparam int RATE_SLOW_MV_PER_US = 1;
	localparam int RATE_FAST_MV_PER_US = 2;
	localparam logic [11:0] STEP_CYC_SLOW = 12'(STEP_MV * CLK_MHZ / RATE_SLOW_MV_PER_US);
	localparam logic [11:0] STEP_CYC_FAST = 12'(STEP_MV * CLK_MHZ / RATE_FAST_MV_PER_US);

	// Initialization delay after the non-volatile load
	localparam logic [3:0] INIT_CYCLES = 4'h8;

	// Strap resistance band edges in kOhm between the eight offsets
	localparam int STRAP_EDGES = 7;
	localparam logic [7:0] STRAP_EDGE_KOHM [STRAP_EDGES] = '{8'h05, 8'h0f, 8'h19, 8'h23, 8'h2b, 8'h33, 8'h3e};

	// Feedback code below which the modulator keeps minimum on-time pulses
	localparam logic [8:0] MIN_ON_EXIT_CODE = 9'h010;

	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum {SEQ_LOCKOUT, SEQ_NVM, SEQ_INIT, SEQ_ADDR, SEQ_READY} seq_t;
	typedef enum {BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_RX, BUS_ACK_RX, BUS_TX, BUS_ACK_TX} bus_t;

endpackage

// *** core/ramp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ramp_link_if;
	logic hard_off;
	logic run;
	logic fast_rate;
	logic [8:0] target;
	logic [8:0] ss_level;
	logic at_zero;
	logic at_target;
	logic strap_capture;
	logic strap_clear;
	logic [7:0] strap_kohm;
	logic strap_valid;
	logic [2:0] offset;
	logic offset_held;

	modport ctrl (output hard_off, run, fast_rate, target, strap_capture, strap_clear, strap_kohm, strap_valid,
		input ss_level, at_zero, at_target, offset, offset_held);
	modport ramp (input hard_off, run, fast_rate, target, output ss_level, at_zero, at_target);
	modport strap (input strap_capture, strap_clear, strap_kohm, strap_valid, output offset, offset_held);
endinterface
`default_nettype wire

// *** core/soft_ramp.sv ***
`timescale 1ns/1ps
`default_nettype none
module soft_ramp import regulator_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	ramp_link_if.ramp lnk
);
	logic [11:0] tick_r;
	logic [8:0] ss_r;
	wire [11:0] period = lnk.fast_rate ? STEP_CYC_FAST : STEP_CYC_SLOW;
	wire tick = (tick_r >= period - 12'h001);
	// Soft-stop steers the goal to zero at the same rate as the rise
	wire [8:0] goal = lnk.run ? lnk.target : 9'h000;

	always_ff @(posedge core_clk) begin
		if (srst || lnk.hard_off) begin
			tick_r <= 12'h000;
			ss_r <= 9'h000;
		end else if (tick) begin
			tick_r <= 12'h000;
			if (ss_r < goal) begin
				ss_r <= ss_r + 9'h001;
			end else if (ss_r > goal) begin
				ss_r <= ss_r - 9'h001;
			end
		end else begin
			tick_r <= tick_r + 12'h001;
		end
	end

	assign lnk.ss_level = ss_r;
	assign lnk.at_zero = (ss_r == 9'h000);
	assign lnk.at_target = lnk.run && (ss_r == lnk.target);
endmodule // soft_ramp
`default_nettype wire

// *** core/strap_offset.sv ***
`timescale 1ns/1ps
`default_nettype none
module strap_offset import regulator_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	ramp_link_if.strap lnk
);
	logic [STRAP_EDGES-1:0] above;
	logic [2:0] band;
	logic [2:0] offset_r;
	logic held_r;

	// One comparator per band edge
	genvar i;
	generate
		for (i = 0; i < STRAP_EDGES; i++) begin : g_edge
			assign above[i] = (lnk.strap_kohm > STRAP_EDGE_KOHM[i]);
		end
	endgenerate

	always_comb begin
		band = 3'h0;
		for (int k = 0; k < STRAP_EDGES; k++) begin
			band = band + {2'b00, above[k]};
		end
	end

	// Caught once, kept until the next bias reset
	always_ff @(posedge core_clk) begin
		if (srst || lnk.strap_clear) begin
			offset_r <= 3'h0;
			held_r <= 1'b0;
		end else if (lnk.strap_capture && lnk.strap_valid && !held_r) begin
			offset_r <= band;
			held_r <= 1'b1;
		end
	end

	assign lnk.offset = offset_r;
	assign lnk.offset_held = held_r;
endmodule // strap_offset
`default_nettype wire

// *** verification/startup_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module startup_ctrl_chk import regulator_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic enable_pin,
	input wire logic port_ready,
	input wire logic sda_oe,
	input wire logic [8:0] feedback_sense,
	input wire logic overcurrent_trip,
	input wire logic high_side_drive,
	input wire logic low_side_drive,
	input wire logic min_on_time,
	input wire logic [8:0] reference_code,
	input wire logic power_good_oe
);
	logic passed_r;
	logic hs_seen_r;
	wire logic drv = high_side_drive | low_side_drive;
	// Ramp has overtaken the sensed output since enable or port ready last dropped
	always_ff @(posedge core_clk) begin
		if (srst || !port_ready || !enable_pin) begin
			passed_r <= 1'b0;
		end else if (reference_code > feedback_sense) begin
			passed_r <= 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hs_seen_r <= 1'b0;
		end else if (high_side_drive) begin
			hs_seen_r <= 1'b1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_enable_drop;
		enable_pin ##1 !enable_pin;
	endsequence
	a_port_silent: assert property ((!port_ready) [*2] |-> !sda_oe)
		else $error("bus answered before ready");
	a_enable_kill: assert property (!enable_pin |-> !drv)
		else $error("drive while disabled");
	a_ref_drop: assert property (s_enable_drop |=> reference_code == 9'h000)
		else $error("reference kept after disable");
	a_ocp_kill: assert property (overcurrent_trip |-> !drv)
		else $error("drive during overcurrent");
	a_prebias_hold: assert property (drv |-> passed_r)
		else $error("drive before ramp passed feedback");
	a_pg_after_pulse: assert property (!power_good_oe |-> hs_seen_r)
		else $error("power good before first pulse");
	a_ramp_unit: assert property ($changed(reference_code) && reference_code != 9'h000 |->
		reference_code == $past(reference_code) + 9'h001 || reference_code + 9'h001 == $past(reference_code))
		else $error("reference jumped");
	a_min_on: assert property (min_on_time |-> $past(feedback_sense) < MIN_ON_EXIT_CODE)
		else $error("minimum on-time above exit code");
endmodule // startup_ctrl_chk
`default_nettype wire

// *** verification/i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input wire logic core_clk,
	input wire logic sda_oe,
	input wire logic sda_out,
	output logic scl_in,
	output logic sda_in
);
	logic scl_r = 1'b1;
	logic sda_r = 1'b1;
	// Pulled-up data wire: low while either side pulls it
	assign scl_in = scl_r;
	assign sda_in = sda_r & (sda_out | !sda_oe);
	// Each bus phase is held four core clocks
	task automatic put(input logic c, input logic d);
		@(posedge core_clk);
		scl_r <= c;
		sda_r <= d;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		put(1'b0, sda_r);
		put(1'b0, b);
		put(1'b1, b);
		r = sda_in;
	endtask
	task automatic start();
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
	endtask
	task automatic stop();
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// Single-byte read, closed with a not-acknowledge
	task automatic rbyte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(1'b1, r);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// *** verification/startup_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module startup_ctrl_tb import regulator_pkg::*; ;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic bias_undervoltage_lockout = 1'b1;
	logic nvm_load_done = 1'b0;
	logic strap_valid = 1'b0;
	logic enable_pin = 1'b0;
	logic pwm_request = 1'b1;
	logic pg_compare = 1'b0;
	logic overcurrent_trip = 1'b0;
	logic overvoltage_trip = 1'b0;
	logic pwm_run = 1'b0;
	logic [8:0] nvm_vout_code = 9'h005;
	logic [7:0] nvm_base_address = BASE_ADDR_RESET;
	logic [7:0] strap_kohm = 8'h00;
	logic [8:0] feedback_sense = 9'h000;
	logic [6:0] dev = 7'h00;
	logic [31:0] xs_state = 32'h0000003c;
	wire logic scl_in, sda_in, sda_out, sda_oe, high_side_drive, low_side_drive, min_on_time;
	wire logic bus_level_high, power_good_output, power_good_oe, port_ready;
	wire logic [8:0] reference_code;
	int n_mismatch = 0;
	int checks_done = 0;
	int waited = 0;
	logic [7:0] reg_addr [6] = '{REG_VOUT_HIGH, REG_VOUT_LOW, REG_RAMP_CTRL, REG_BUS_LEVEL, REG_STOP_ARM, REG_BASE_ADDR};
	int mdl [6];
	logic [7:0] kohm_tab [8] = '{8'h00, 8'h0a, 8'h14, 8'h1e, 8'h27, 8'h2f, 8'h38, 8'h44};
	startup_ctrl uut (.core_clk, .srst, .bias_undervoltage_lockout, .nvm_load_done, .nvm_vout_code, .nvm_base_address,
		.strap_kohm, .strap_valid, .scl_in, .sda_in, .sda_out, .sda_oe, .enable_pin, .pwm_request, .feedback_sense,
		.pg_compare, .overcurrent_trip, .overvoltage_trip, .high_side_drive, .low_side_drive, .min_on_time,
		.reference_code, .bus_level_high, .power_good_output, .power_good_oe, .port_ready);
	i2c_master_model m (.core_clk, .sda_oe, .sda_out, .scl_in, .sda_in);
	always #2.5 core_clk = ~core_clk;
	function automatic logic [31:0] xs();
		xs_state = xs_state ^ (xs_state << 13);
		xs_state = xs_state ^ (xs_state >> 17);
		xs_state = xs_state ^ (xs_state << 5);
		return xs_state;
	endfunction
	always @(posedge core_clk) begin
		pwm_request <= pwm_run ? ^xs() : 1'b1;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_until(input bit on_ref, input logic [8:0] v, input int lim);
		for (waited = 0; waited < lim; waited++) begin
			if (on_ref ? reference_code === v : port_ready === 1'b1) break;
			@(posedge core_clk);
		end
		if (waited == lim) begin
			n_mismatch++;
			$display("Error wait timed out");
			conclude();
		end
	endtask
	task automatic probe(output logic ack);
		m.start();
		m.wbyte({dev, 1'b0}, ack);
		m.stop();
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		logic k;
		m.start();
		m.wbyte({dev, 1'b0}, k);
		m.wbyte(a, k);
		m.start();
		m.wbyte({dev, 1'b1}, k);
		m.rbyte(d);
		m.stop();
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		logic k1, k2, k3;
		m.start();
		m.wbyte({dev, 1'b0}, k1);
		m.wbyte(reg_addr[i], k2);
		m.wbyte(d, k3);
		m.stop();
		check("write ack", {k1, k2, k3}, 3'h7);
		mdl[i] = d;
	endtask
	initial begin
		logic a;
		logic [7:0] d;
		logic [8:0] tgt;
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		strap_valid <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge core_clk);
			bias_undervoltage_lockout <= 1'b1;
			nvm_load_done <= 1'b0;
			strap_kohm <= kohm_tab[k];
			@(posedge core_clk);
			bias_undervoltage_lockout <= 1'b0;
			dev = 7'(BASE_ADDR_RESET + 8'(k));
			probe(a);
			check("early ack", a, 1'b0);
			nvm_load_done <= 1'b1;
			wait_until(0, 0, 200);
			strap_kohm <= 8'hff;
			probe(a);
			check("offset ack", a, 1'b1);
		end
		dev = 7'h10;
		probe(a);
		check("foreign ack", a, 1'b0);
		dev = 7'h0f;
		mdl = '{int'(nvm_vout_code[8]), int'(nvm_vout_code[7:0]), 0, 0, 0, int'(BASE_ADDR_RESET)};
		for (int i = 0; i < 6; i++) begin
			reg_rd(reg_addr[i], d);
			check("register", d, 16'(mdl[i]));
		end
		reg_rd(8'h20, d);
		check("unmapped", d, 8'h00);
		wr(3, 8'h02);
		check("bus level", bus_level_high, 1'b1);
		// Target stays within a fifth of the stored default code
		tgt = 9'h004 + 9'(xs() % 3);
		wr(0, 8'h00);
		wr(1, tgt[7:0]);
		wr(4, 8'h08);
		feedback_sense <= 9'h002;
		pg_compare <= 1'b1;
		pwm_run <= 1'b1;
		enable_pin <= 1'b1;
		wait_until(1, tgt, 16000);
		check("slow ramp", waited + 4 >= (int'(tgt) - 1) * int'(STEP_CYC_SLOW), 1'b1);
		check("ramp end", reference_code, tgt);
		repeat (20) @(posedge core_clk);
		check("power good", {power_good_output, power_good_oe}, 2'b00);
		check("min on", min_on_time, 1'b1);
		reg_rd(REG_STATUS, d);
		check("status", d, 8'h03);
		wr(2, 8'h04);
		wait_until(1, 1, 16000);
		pwm_run <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("drive in stop", high_side_drive, 1'b1);
		wait_until(1, 0, 4000);
		repeat (2) @(posedge core_clk);
		check("stopped", {high_side_drive, low_side_drive}, 2'b00);
		pwm_run <= 1'b1;
		wr(2, 8'h08);
		wait_until(1, tgt, 8000);
		check("fast ramp", waited <= int'(tgt) * int'(STEP_CYC_FAST) + 50, 1'b1);
		pwm_run <= 1'b0;
		enable_pin <= 1'b0;
		overcurrent_trip <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("hard off", {reference_code, high_side_drive}, 10'h000);
		overcurrent_trip <= 1'b0;
		enable_pin <= 1'b1;
		wait_until(1, 1, 2000);
		overvoltage_trip <= 1'b1;
		@(posedge core_clk);
		overvoltage_trip <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("ovp off", {reference_code, high_side_drive, low_side_drive}, 11'h000);
		reg_rd(REG_STATUS, d);
		check("ovp status", d, 8'h04);
		conclude();
	end
endmodule // startup_ctrl_tb
bind startup_ctrl startup_ctrl_chk chk (.core_clk, .srst, .enable_pin, .port_ready, .sda_oe, .feedback_sense,
	.overcurrent_trip, .high_side_drive, .low_side_drive, .min_on_time, .reference_code, .power_good_oe);
`default_nettype wire
